/* File: hdl/sefc_regs.vh */
// Purpose: Constants for the switching edge and frequency configuration bank
// Assumes: 8-bit registers at byte offsets on the management bus
// Notes:   Reset values are plain defaults; no reset value is documented
`ifndef SEFC_REGS_VH
`define SEFC_REGS_VH

// Register offsets
`define SEFC_ADDR_W          8
`define SEFC_OFS_SLEW        8'h02
`define SEFC_OFS_FREQ        8'h03

// Reset values
`define SEFC_RST_SLEW        8'h00
`define SEFC_RST_FREQ        8'h08

// Slew register field positions
`define SEFC_A_RISE_HI       7
`define SEFC_A_RISE_LO       6
`define SEFC_A_FALL_HI       5
`define SEFC_A_FALL_LO       4
`define SEFC_B_RISE_HI       3
`define SEFC_B_RISE_LO       2
`define SEFC_B_FALL_HI       1
`define SEFC_B_FALL_LO       0

// Slew codes
`define SEFC_SLEW_1VNS       2'h0
`define SEFC_SLEW_2VNS       2'h1

// Frequency register fields
`define SEFC_SYNC_HI         7
`define SEFC_SYNC_LO         6
`define SEFC_FSW_HI          5
`define SEFC_FSW_LO          0

// Sync modes
`define SEFC_SYNC_OFF        2'h0
`define SEFC_SYNC_IN         2'h1
`define SEFC_SYNC_OUT0       2'h2
`define SEFC_SYNC_OUT180     2'h3

// Frequency code limits and step
`define SEFC_FSW_MIN         6'h04
`define SEFC_FSW_MAX         6'h2c
`define SEFC_FSW_STEP_KHZ    12'h032
`define SEFC_FSW_SAT_KHZ     12'h898

`endif

/* File: hdl/sefc_bank.v */
// Purpose: Slew-rate and sync/frequency configuration registers
// Assumes: Bus write and read strobes come from logic on clk
// Notes:   Decoded outputs feed the analog power stage
//
// Overview of operation
// RULE_01 - Slew code 0 is 1 V/ns, 1 is 2 V/ns
// RULE_02 - Slew bits 7:6/5:4 are node A rise/fall
// RULE_03 - Slew bits 3:2/1:0 are node B rise/fall
// RULE_04 - Sync bits 7:6; 0 off, 1 clock in
// RULE_05 - Sync 2 clock out 0 deg, 3 180 deg
// RULE_06 - Codes 4..44 give code times 50 kHz
// RULE_07 - Codes 45..63 saturate at 2.2 MHz
// RULE_08 - Host keeps frequency at or below 1 MHz
// RULE_09 - Registers read back last written, no side effects
// RULE_10 - Host avoids writing reserved codes
`include "sefc_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module sefc_bank (
	// Clock, reset, enable
	input  wire        clk,
	input  wire        rst_b,
	input  wire        clk_en,
	// Register port
	input  wire [7:0]  reg_addr,
	input  wire        reg_wr,
	input  wire [7:0]  reg_wdata,
	input  wire        reg_rd,
	output reg  [7:0]  reg_rdata,
	output reg         reg_rvalid,
	// Slew settings, 1 = fast 2 V/ns
	output reg         node_a_rise_fast,
	output reg         node_a_fall_fast,
	output reg         node_b_rise_fast,
	output reg         node_b_fall_fast,
	output reg         slew_reserved,
	// Sync and frequency settings
	output reg         sync_pin_input,
	output reg         sync_pin_output,
	output reg         sync_out_invert,
	output reg  [11:0] switching_freq_khz,
	output reg         freq_reserved
);

	// Stored register images, kept at full width for readback
	reg  [7:0]  switch_node_slew_rate_r;
	reg  [7:0]  sync_and_switching_frequency_r;

	// Next values of the stored images
	wire [7:0]  switch_node_slew_rate_nxt;
	wire [7:0]  sync_and_switching_frequency_nxt;

	// Address hits, shared by the write path
	wire        hit_slew;
	wire        hit_freq;

	// Raw fields, named after what they steer
	wire [1:0]  node_a_rise_rate;
	wire [1:0]  node_a_fall_rate;
	wire [1:0]  node_b_rise_rate;
	wire [1:0]  node_b_fall_rate;
	wire [1:0]  sync_mode;
	wire [5:0]  switching_frequency_code;

	// Decoded values ahead of the output flops
	wire        slew_rsv_nxt;
	wire        sync_in_nxt;
	wire        sync_out_nxt;
	wire        sync_inv_nxt;
	wire [11:0] freq_khz_nxt;
	wire        freq_rsv_nxt;

	// Read mux result, registered on a read strobe
	reg  [7:0]  rdata_nxt;

	// Slew code to fast flag.
	// Reserved codes fall back to the slow edge: a slower edge costs
	// some loss but never adds ringing, so it is the safe default.
	function slew_fast;
		input [1:0] code;
		begin
			slew_fast = (code == `SEFC_SLEW_2VNS); // RULE_01
		end
	endfunction

	// Slew code reserved check, used for all four fields
	function slew_rsv;
		input [1:0] code;
		begin
			slew_rsv = (code != `SEFC_SLEW_1VNS) &&
				(code != `SEFC_SLEW_2VNS);
		end
	endfunction

	// Frequency code to kHz.
	// Low reserved codes report zero so the stage can hold off; codes
	// above the linear range saturate at the fixed ceiling.
	// The product fits 12 bits: the largest linear code gives 2200.
	function [11:0] freq_khz;
		input [5:0] code;
		begin
			if (code < `SEFC_FSW_MIN) begin
				freq_khz = 12'h000;
			end else if (code > `SEFC_FSW_MAX) begin
				freq_khz = `SEFC_FSW_SAT_KHZ; // RULE_07
			end else begin
				freq_khz = {6'h00, code} * `SEFC_FSW_STEP_KHZ; // RULE_06
			end
		end
	endfunction

	// Low frequency code check, flags the reserved bottom range
	function freq_low;
		input [5:0] code;
		begin
			freq_low = (code < `SEFC_FSW_MIN); // RULE_06
		end
	endfunction

	// Address decode; only the two mapped offsets take writes
	assign hit_slew = (reg_addr == `SEFC_OFS_SLEW);
	assign hit_freq = (reg_addr == `SEFC_OFS_FREQ);

	// Register write next values; other offsets leave both untouched
	assign switch_node_slew_rate_nxt =
		(reg_wr && hit_slew) ? reg_wdata : switch_node_slew_rate_r;
	assign sync_and_switching_frequency_nxt =
		(reg_wr && hit_freq) ? reg_wdata :
		sync_and_switching_frequency_r;

	// Slew field extraction
	assign node_a_rise_rate =
		switch_node_slew_rate_r[`SEFC_A_RISE_HI:`SEFC_A_RISE_LO]; // RULE_02
	assign node_a_fall_rate =
		switch_node_slew_rate_r[`SEFC_A_FALL_HI:`SEFC_A_FALL_LO]; // RULE_02
	assign node_b_rise_rate =
		switch_node_slew_rate_r[`SEFC_B_RISE_HI:`SEFC_B_RISE_LO]; // RULE_03
	assign node_b_fall_rate =
		switch_node_slew_rate_r[`SEFC_B_FALL_HI:`SEFC_B_FALL_LO]; // RULE_03

	// Sync and frequency field extraction
	assign sync_mode =
		sync_and_switching_frequency_r[`SEFC_SYNC_HI:`SEFC_SYNC_LO]; // RULE_04
	assign switching_frequency_code =
		sync_and_switching_frequency_r[`SEFC_FSW_HI:`SEFC_FSW_LO]; // RULE_06

	// Slew decode; any reserved field raises one shared flag
	assign slew_rsv_nxt = slew_rsv(node_a_rise_rate) |
		slew_rsv(node_a_fall_rate) |
		slew_rsv(node_b_rise_rate) |
		slew_rsv(node_b_fall_rate); // RULE_01

	// Sync decode; output modes share the driver, 180 deg sets invert
	assign sync_in_nxt  = (sync_mode == `SEFC_SYNC_IN); // RULE_04
	assign sync_out_nxt = (sync_mode == `SEFC_SYNC_OUT0) ||
		(sync_mode == `SEFC_SYNC_OUT180); // RULE_05
	assign sync_inv_nxt = (sync_mode == `SEFC_SYNC_OUT180); // RULE_05

	// Frequency decode; no 1 MHz cap here, that limit is the host's
	assign freq_khz_nxt = freq_khz(switching_frequency_code);
	assign freq_rsv_nxt = freq_low(switching_frequency_code);

	// Read mux; unmapped offsets return zero so probing is harmless
	always @* begin
		case (reg_addr)
		`SEFC_OFS_SLEW: begin
			rdata_nxt = switch_node_slew_rate_r; // RULE_09
		end
		`SEFC_OFS_FREQ: begin
			rdata_nxt = sync_and_switching_frequency_r; // RULE_09
		end
		default: begin
			rdata_nxt = 8'h00;
		end
		endcase
	end

	// Storage; full 8 bits kept so reserved codes read back as written.
	// A low enable freezes the images, so a strobe then is lost.
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			switch_node_slew_rate_r        <= `SEFC_RST_SLEW;
			sync_and_switching_frequency_r <= `SEFC_RST_FREQ;
		end else if (clk_en) begin
			switch_node_slew_rate_r        <= switch_node_slew_rate_nxt; // RULE_09
			sync_and_switching_frequency_r <=
				sync_and_switching_frequency_nxt; // RULE_09
		end
	end

	// Read path; reads only load the data flop, no state is touched.
	// Read data holds between reads, valid follows the read strobe one enabled edge later.
	// A read in the cycle of a write to the same offset sees the old
	// value, since the mux looks at the images before the edge.
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata  <= 8'h00;
			reg_rvalid <= 1'b0;
		end else if (clk_en) begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				reg_rdata <= rdata_nxt; // RULE_09
			end
		end
	end

	// Decoded settings, registered so every output is a flip-flop.
	// They follow a write by one enabled edge; the stage sees no
	// glitch while the bus strobes move.
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			node_a_rise_fast   <= 1'b0;
			node_a_fall_fast   <= 1'b0;
			node_b_rise_fast   <= 1'b0;
			node_b_fall_fast   <= 1'b0;
			slew_reserved      <= 1'b0;
			sync_pin_input     <= 1'b0;
			sync_pin_output    <= 1'b0;
			sync_out_invert    <= 1'b0;
			switching_freq_khz <= 12'h000;
			freq_reserved      <= 1'b0;
		end else if (clk_en) begin
			node_a_rise_fast   <= slew_fast(node_a_rise_rate); // RULE_02
			node_a_fall_fast   <= slew_fast(node_a_fall_rate); // RULE_02
			node_b_rise_fast   <= slew_fast(node_b_rise_rate); // RULE_03
			node_b_fall_fast   <= slew_fast(node_b_fall_rate); // RULE_03
			slew_reserved      <= slew_rsv_nxt; // RULE_01
			sync_pin_input     <= sync_in_nxt; // RULE_04
			sync_pin_output    <= sync_out_nxt; // RULE_05
			sync_out_invert    <= sync_inv_nxt; // RULE_05
			switching_freq_khz <= freq_khz_nxt; // RULE_06
			freq_reserved      <= freq_rsv_nxt; // RULE_06
		end
	end

	// Limitation: the decoded outputs are plain levels; a stage that
	// must not switch on a reserved code has to watch the two flags.

endmodule

`default_nettype wire

/* File: tb/sefc_bank_checker.sv */
// Purpose: Port assertions for the configuration bank
// Assumes: Decode lands one enabled edge after its write
// Notes:   d is the write data of two edges back
`timescale 1ns/1ps
`default_nettype none
module sefc_chk (
	// Clock, reset, enable
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic        clk_en,
	// Register port
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic        reg_rvalid,
	input wire logic [7:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	// Slew settings
	input wire logic        node_a_rise_fast,
	input wire logic        node_a_fall_fast,
	input wire logic        node_b_rise_fast,
	input wire logic        node_b_fall_fast,
	input wire logic        slew_reserved,
	// Sync and frequency settings
	input wire logic        sync_pin_input,
	input wire logic        sync_pin_output,
	input wire logic        sync_out_invert,
	input wire logic        freq_reserved,
	input wire logic [11:0] switching_freq_khz
);
	logic [7:0] c, d;
	// Delay line, so d lines up with the decode of its write
	always @(posedge clk) {d, c} <= {c, reg_wdata};
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence w2; clk_en && reg_wr && reg_addr == 8'h02 ##1 clk_en; endsequence
	sequence w3; clk_en && reg_wr && reg_addr == 8'h03 ##1 clk_en; endsequence
	property p_ar; w2 |=> node_a_rise_fast == (d[7:6] == 2'h1); endproperty
	a_ar: assert property (p_ar) else $error("node a rise");
	property p_br; w2 |=> node_b_rise_fast == (d[3:2] == 2'h1); endproperty
	a_br: assert property (p_br) else $error("node b rise");
	property p_af; w2 |=> node_a_fall_fast == (d[5:4] == 2'h1); endproperty
	a_af: assert property (p_af) else $error("node a fall");
	property p_bf; w2 |=> node_b_fall_fast == (d[1:0] == 2'h1); endproperty
	a_bf: assert property (p_bf) else $error("node b fall");
	property p_rs; w2 |=> slew_reserved == |(d & 8'haa); endproperty
	a_rs: assert property (p_rs) else $error("slew code");
	property p_si; w3 |=> sync_pin_input == (d[7:6] == 2'h1); endproperty
	a_si: assert property (p_si) else $error("sync in");
	property p_so; w3 |=> {sync_pin_output, sync_out_invert} == {d[7], &d[7:6]};
	endproperty
	a_so: assert property (p_so) else $error("sync out");
	property p_fl; w3 |=> switching_freq_khz == (d[5:0] > 6'h2c ? 12'h898 :
		d[5:0] < 6'h04 ? 12'h000 : d[5:0] * 12'h032); endproperty
	a_fl: assert property (p_fl) else $error("freq");
	property p_fr; w3 |=> freq_reserved == (d[5:0] < 6'h04); endproperty
	a_fr: assert property (p_fr) else $error("freq code");
	property p_rv; clk_en && reg_rd |=> reg_rvalid; endproperty
	a_rv: assert property (p_rv) else $error("read valid");
endmodule
bind sefc_bank sefc_chk u_chk (.*);
`default_nettype wire

/* File: tb/sefc_host.sv */
// Purpose: Host model for the register strobes
// Assumes: Strobes move on the falling edge
// Notes:   Codes are not screened, so reserved ones reach the bank
`timescale 1ns/1ps
`default_nettype none
module sefc_host (
	// Clock and read data
	input  wire logic       clk,
	input  wire logic [7:0] reg_rdata,
	// Strobes, address, write data
	output var  logic [7:0] reg_addr,
	output var  logic [7:0] reg_wdata,
	output var  logic       reg_wr,
	output var  logic       reg_rd
);
	// Idle bus; range limits are the caller's duty
	initial {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h0;
	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, v);
		@(negedge clk) {reg_addr, reg_wdata, reg_wr} = {a, v, 1'b1};
		@(negedge clk) reg_wr = 1'b0;
	endtask
	// Read data is settled by the falling edge after the answer edge
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		@(negedge clk) {reg_addr, reg_rd} = {a, 1'b1};
		@(negedge clk) reg_rd = 1'b0;
		@(negedge clk) q = reg_rdata;
	endtask
endmodule
`default_nettype wire

/* File: tb/sefc_bank_bench.sv */
// Purpose: Self-checking bench for the configuration bank
// Assumes: sefc_host owns the register strobes
// Notes:   Corner bytes first, then seeded random ones
`timescale 1ns/1ps
`default_nettype none
module sefc_bank_bench;
	logic clk = 0, rst_b = 0, clk_en = 1, reg_wr, reg_rd, reg_rvalid;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, v, q;
	logic node_a_rise_fast, node_a_fall_fast, node_b_rise_fast;
	logic node_b_fall_fast, slew_reserved, sync_pin_input;
	logic sync_pin_output, sync_out_invert, freq_reserved;
	logic [11:0] switching_freq_khz;
	wire logic [3:0] sl = {node_a_rise_fast, node_a_fall_fast,
		node_b_rise_fast, node_b_fall_fast};
	wire logic [3:0] sy = {sync_pin_input, sync_pin_output, sync_out_invert,
		freq_reserved};
	// Every sync mode, frequency edges 03/04/2c/2d/3f, all slew codes
	localparam logic [47:0] cv = 48'h0344aced7f14;
	int n_fail = 0, n_tests = 0;
	sefc_bank u_dut (.*);
	sefc_host u_host (.*);
	initial forever #4 clk = ~clk;
	// Expected kHz: zero when reserved, capped above the linear range
	function automatic logic [11:0] f(input logic [5:0] c);
		return c < 6'h04 ? 12'h000 : c > 6'h2c ? 12'h898 : c * 12'h032;
	endfunction
	task automatic chk(input string n, input logic [11:0] s, e);
		n_tests++;
		if (s !== e) begin
			n_fail++;
			$display("MISMATCH %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// Same byte into both registers, then decode and readback
	initial begin
		void'($urandom(405));
		repeat (12) @(negedge clk);
		rst_b = 1'b1;
		for (int i = 0; i < 40; i++) begin
			v = i < 6 ? cv[8*i +: 8] : 8'($urandom);
			u_host.wr(8'h02, v);
			u_host.wr(8'h03, v);
			@(negedge clk);
			for (int k = 0; k < 4; k++)
				chk("slew", sl[k], v[2*k +: 2] == 2'h1);
			chk("slew rsv", slew_reserved, |(v & 8'haa));
			chk("sync", sy, {v[7:6] == 2'h1, v[7], &v[7:6],
				v[5:0] < 6'h04});
			chk("khz", switching_freq_khz, f(v[5:0]));
			u_host.rd(8'h02, q);
			chk("rd slew", q, v);
			u_host.rd(8'h03, q);
			chk("rd freq", q, v);
			$display("test %0d done", i);
		end
		// Unmapped offset is ignored and reads as zero
		u_host.wr(8'h04, 8'hff);
		u_host.rd(8'h04, q);
		chk("rd unmapped", q, 8'h00);
		u_host.rd(8'h02, q);
		chk("rd slew kept", q, v);
		u_host.rd(8'h03, q);
		chk("rd freq kept", q, v);
		$display("test unmapped done");
		// Low enable: a write is lost and the decode holds
		@(negedge clk) clk_en = 1'b0;
		u_host.wr(8'h03, ~v);
		@(negedge clk) clk_en = 1'b1;
		@(negedge clk);
		chk("frozen khz", switching_freq_khz, f(v[5:0]));
		u_host.rd(8'h03, q);
		chk("frozen rd", q, v);
		$display("test enable done");
		// Mid-run reset: outputs clear, then reset images decode
		@(negedge clk) rst_b = 1'b0;
		@(negedge clk);
		chk("rst khz", switching_freq_khz, 12'h000);
		chk("rst sync", sy, 4'h0);
		@(negedge clk) rst_b = 1'b1;
		@(negedge clk);
		// Reset image 08 decodes to 400 kHz
		chk("rel khz", switching_freq_khz, 12'h190);
		u_host.rd(8'h03, q);
		chk("rel rd freq", q, 8'h08);
		u_host.rd(8'h02, q);
		chk("rel rd slew", q, 8'h00);
		$display("test reset done");
		wrap_up;
	end
endmodule
`default_nettype wire
